/* File: rtl/ebi_pkg.sv */
package ebi_pkg;

  // Address and timing
  localparam logic [19:0] RESET_VECTOR   = 20'h0FF80;
  localparam logic [3:0]  ROM_PAGE       = 4'hF;
  localparam int          WS_WIDTH       = 3;
  localparam logic [2:0]  READY_MIN_WS   = 3'h2;
  localparam logic [2:0]  LAST_WAIT      = 3'h1;

  // Reset values
  localparam logic        FLAG_RESET     = 1'b1;
  localparam logic        KEEPER_RESET   = 1'b0;

  typedef enum logic [1:0] {
    EBI_SPACE_DATA = 2'h0,
    EBI_SPACE_PROG = 2'h1,
    EBI_SPACE_IO   = 2'h2
  } ebi_space_type;

  // Gray codes along idle, access, wait, ready check
  typedef enum logic [2:0] {
    EBI_IDLE   = 3'h0,
    EBI_ACCESS = 3'h1,
    EBI_WAIT   = 3'h3,
    EBI_RDY    = 3'h2,
    EBI_HOLD   = 3'h6
  } ebi_state_type;

  typedef struct packed {
    ebi_space_type        space;
    logic                 write;
    logic [19:0]          addr;
    logic [15:0]          wdata;
    logic [WS_WIDTH-1:0]  wait_states;
  } ebi_req_type;

  typedef struct packed {
    logic data_space_select_n;
    logic program_space_select_n;
    logic io_space_select_n;
    logic memory_strobe_n;
    logic io_strobe_n;
    logic rw;
  } ebi_ctrl_type;

  localparam ebi_ctrl_type CTRL_IDLE = 6'h3F;

endpackage

/* File: rtl/ebi_bus_interface.sv */
`timescale 1ns/100ps
module ebi_bus_interface #(
  parameter int ADDR_WIDTH = 20,
  parameter int DATA_WIDTH = 16
) (
  // Clock and reset
  input  logic                    clock_i,
  input  logic                    reset_i,
  input  logic                    reset_in_n_i,
  // Core access port
  input  logic                    req_valid_i,
  input  ebi_pkg::ebi_req_type    req_i,
  output logic                    req_ready_o,
  output logic                    ack_o,
  output logic                    rom_hit_o,
  output logic [DATA_WIDTH-1:0]   rdata_o,
  // Core control and status
  output logic                    cpu_reset_o,
  output logic                    fetch_start_o,
  output logic [ADDR_WIDTH-1:0]   fetch_addr_o,
  input  logic                    processor_mode_status_write_i,
  input  logic                    processor_mode_status_mode_i,
  output logic                    rom_mapped_o,
  input  logic                    keeper_write_i,
  input  logic                    keeper_value_i,
  input  logic                    decode_phase_i,
  input  logic                    read_phase_i,
  input  logic                    conditional_execute_instr_i,
  output logic                    branch_taken_o,
  input  logic                    set_status_bit_instr_i,
  input  logic                    clear_status_bit_instr_i,
  input  logic                    status_word_one_load_i,
  // Device pins
  input  logic                    boot_memory_mode_select_i,
  input  logic                    branch_condition_input_i,
  input  logic                    ready_i,
  input  logic                    hold_n_i,
  input  logic                    output_disable_n_i,
  output logic                    external_flag_output_o,
  output logic                    external_flag_output_oe_o,
  output ebi_pkg::ebi_ctrl_type   ctrl_o,
  output logic                    ctrl_oe_o,
  output logic [ADDR_WIDTH-1:0]   addr_o,
  output logic                    addr_oe_o,
  input  logic [DATA_WIDTH-1:0]   data_i,
  output logic [DATA_WIDTH-1:0]   data_o,
  output logic                    data_oe_o,
  output logic                    bus_keeper_enable_o,
  output logic                    bus_grant_n_o,
  output logic                    bus_grant_n_oe_o,
  output logic                    microstate_done_n_o
);

  ebi_pkg::ebi_state_type              state_reg;
  ebi_pkg::ebi_state_type              state_next;
  ebi_pkg::ebi_req_type                req_reg;
  logic [ebi_pkg::WS_WIDTH-1:0]        count_reg;
  logic                                mode_reg;
  logic                                flag_reg;
  logic                                keeper_reg;
  logic                                branch_reg;
  logic                                in_reset_reg;
  logic                                fetch_reg;
  logic                                ack_reg;
  logic                                rom_hit_reg;
  logic [DATA_WIDTH-1:0]               rdata_reg;
  logic                                cpu_rst;
  logic                                rom_hit;
  logic                                done;
  logic                                active;

  assign cpu_rst = reset_i || !reset_in_n_i;
  assign active  = (state_reg == ebi_pkg::EBI_ACCESS) || (state_reg == ebi_pkg::EBI_WAIT)
                || (state_reg == ebi_pkg::EBI_RDY);
  assign rom_hit = !mode_reg && (req_i.space == ebi_pkg::EBI_SPACE_PROG)
                && (req_i.addr[15:12] == ebi_pkg::ROM_PAGE);
  assign req_ready_o = (state_reg == ebi_pkg::EBI_IDLE) && hold_n_i && !cpu_rst;

  // Access completes after base cycle and software waits, with a ready check only after two or more waits
  always_comb begin
    done = 1'b0;
    case (state_reg)
      ebi_pkg::EBI_ACCESS: done = (req_reg.wait_states == '0);
      ebi_pkg::EBI_WAIT:   done = (count_reg == ebi_pkg::LAST_WAIT)
                               && (req_reg.wait_states < ebi_pkg::READY_MIN_WS);
      ebi_pkg::EBI_RDY:    done = ready_i;
      default:             done = 1'b0;
    endcase
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ebi_pkg::EBI_IDLE: begin
        if (!hold_n_i) begin
          state_next = ebi_pkg::EBI_HOLD;
        end else if (req_valid_i && !rom_hit) begin
          state_next = ebi_pkg::EBI_ACCESS;
        end
      end
      ebi_pkg::EBI_ACCESS: begin
        state_next = done ? ebi_pkg::EBI_IDLE : ebi_pkg::EBI_WAIT;
      end
      ebi_pkg::EBI_WAIT: begin
        if (done) begin
          state_next = ebi_pkg::EBI_IDLE;
        end else if (count_reg == ebi_pkg::LAST_WAIT) begin
          state_next = ebi_pkg::EBI_RDY;
        end
      end
      ebi_pkg::EBI_RDY: begin
        if (done) begin
          state_next = ebi_pkg::EBI_IDLE;
        end
      end
      ebi_pkg::EBI_HOLD: begin
        if (hold_n_i) begin
          state_next = ebi_pkg::EBI_IDLE;
        end
      end
      default: state_next = ebi_pkg::EBI_IDLE;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (cpu_rst) begin
      state_reg <= ebi_pkg::EBI_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clock_i) begin
    if (cpu_rst) begin
      req_reg   <= '0;
      count_reg <= '0;
    end else if (state_reg == ebi_pkg::EBI_IDLE && state_next == ebi_pkg::EBI_ACCESS) begin
      req_reg   <= req_i;
      count_reg <= req_i.wait_states;
    end else if (state_reg == ebi_pkg::EBI_WAIT) begin
      count_reg <= count_reg - ebi_pkg::LAST_WAIT;
    end
  end

  // Answer to the core, data captured on the completing cycle
  always_ff @(posedge clock_i) begin
    if (cpu_rst) begin
      ack_reg     <= 1'b0;
      rom_hit_reg <= 1'b0;
      rdata_reg   <= '0;
    end else begin
      ack_reg     <= (active && done) || (req_ready_o && req_valid_i && rom_hit);
      rom_hit_reg <= req_ready_o && req_valid_i && rom_hit;
      if (active && done && !req_reg.write) begin
        rdata_reg <= data_i;
      end
    end
  end

  // Boot mode caught while reset is held, then software may override
  always_ff @(posedge clock_i) begin
    if (cpu_rst) begin
      mode_reg <= boot_memory_mode_select_i;
    end else if (processor_mode_status_write_i) begin
      mode_reg <= processor_mode_status_mode_i;
    end
  end

  always_ff @(posedge clock_i) begin
    in_reset_reg <= cpu_rst;
    fetch_reg    <= in_reset_reg && !cpu_rst;
  end

  always_ff @(posedge clock_i) begin
    if (cpu_rst) begin
      flag_reg <= ebi_pkg::FLAG_RESET;
    end else if (clear_status_bit_instr_i || status_word_one_load_i) begin
      flag_reg <= 1'b0;
    end else if (set_status_bit_instr_i) begin
      flag_reg <= 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (cpu_rst) begin
      keeper_reg <= ebi_pkg::KEEPER_RESET;
    end else if (keeper_write_i) begin
      keeper_reg <= keeper_value_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (cpu_rst) begin
      branch_reg <= 1'b0;
    end else if (conditional_execute_instr_i ? decode_phase_i : read_phase_i) begin
      branch_reg <= !branch_condition_input_i;
    end
  end

  // Pin drive
  always_comb begin
    ctrl_o = ebi_pkg::CTRL_IDLE;
    if (active) begin
      ctrl_o.data_space_select_n    = (req_reg.space != ebi_pkg::EBI_SPACE_DATA);
      ctrl_o.program_space_select_n = (req_reg.space != ebi_pkg::EBI_SPACE_PROG);
      ctrl_o.io_space_select_n      = (req_reg.space != ebi_pkg::EBI_SPACE_IO);
      ctrl_o.memory_strobe_n        = (req_reg.space == ebi_pkg::EBI_SPACE_IO);
      ctrl_o.io_strobe_n            = (req_reg.space != ebi_pkg::EBI_SPACE_IO);
      ctrl_o.rw                     = !req_reg.write;
    end
  end

  assign ctrl_oe_o = output_disable_n_i && (state_reg != ebi_pkg::EBI_HOLD);
  assign addr_oe_o = ctrl_oe_o;
  assign addr_o    = (req_reg.space == ebi_pkg::EBI_SPACE_PROG)
                   ? req_reg.addr : {4'h0, req_reg.addr[15:0]};
  assign data_o    = req_reg.wdata;
  assign data_oe_o = ctrl_oe_o && active && req_reg.write && !cpu_rst;
  assign bus_grant_n_o    = (state_reg != ebi_pkg::EBI_HOLD);
  assign bus_grant_n_oe_o = output_disable_n_i;
  assign microstate_done_n_o = !((state_reg == ebi_pkg::EBI_WAIT)
                             && (req_reg.wait_states >= ebi_pkg::READY_MIN_WS)
                             && (count_reg != ebi_pkg::LAST_WAIT));
  assign external_flag_output_o    = flag_reg;
  assign external_flag_output_oe_o = output_disable_n_i;
  assign bus_keeper_enable_o = keeper_reg;
  assign cpu_reset_o    = cpu_rst;
  assign fetch_start_o  = fetch_reg;
  assign fetch_addr_o   = ebi_pkg::RESET_VECTOR;
  assign rom_mapped_o   = !mode_reg;
  assign branch_taken_o = branch_reg;
  assign ack_o          = ack_reg;
  assign rom_hit_o      = rom_hit_reg;
  assign rdata_o        = rdata_reg;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  sequence s_last_wait;
    state_reg == ebi_pkg::EBI_WAIT && count_reg == ebi_pkg::LAST_WAIT;
  endsequence

  sequence s_short_wait;
    req_reg.wait_states < ebi_pkg::READY_MIN_WS;
  endsequence

  a_fetch_vector: assert property ($fell(cpu_rst) |=> fetch_start_o)
    else $error("no fetch start after reset release");
  a_flag_reset: assert property (!reset_in_n_i |=> external_flag_output_o)
    else $error("flag not high after reset");
  a_flag_clear: assert property (!cpu_rst && clear_status_bit_instr_i
    |=> !external_flag_output_o)
    else $error("flag not cleared");
  a_flag_set: assert property (!cpu_rst && set_status_bit_instr_i
    && !clear_status_bit_instr_i && !status_word_one_load_i |=> external_flag_output_o)
    else $error("flag not set");
  a_select_idle: assert property (!active |-> ctrl_o == ebi_pkg::CTRL_IDLE)
    else $error("control active outside an access");
  a_strobe_space: assert property (!ctrl_o.memory_strobe_n
    |-> ctrl_o.io_strobe_n && ctrl_o.io_space_select_n)
    else $error("memory strobe during io access");
  a_io_strobe: assert property (!ctrl_o.io_strobe_n
    |-> !ctrl_o.io_space_select_n && ctrl_o.memory_strobe_n)
    else $error("io strobe outside an io access");
  a_write_dir: assert property (!ctrl_o.rw |-> data_oe_o || !ctrl_oe_o)
    else $error("write direction without data drive");
  a_hold_float: assert property (state_reg == ebi_pkg::EBI_HOLD
    |-> !ctrl_oe_o && !bus_grant_n_o && !data_oe_o)
    else $error("bus driven in hold");
  a_ready_retry: assert property (state_reg == ebi_pkg::EBI_RDY && !ready_i
    && !cpu_rst |=> state_reg == ebi_pkg::EBI_RDY)
    else $error("ready low did not extend access");
  a_ready_skip: assert property (s_last_wait ##0 s_short_wait ##0 !cpu_rst
    |=> state_reg == ebi_pkg::EBI_IDLE)
    else $error("ready checked with fewer than two waits");
  a_ready_gate: assert property (state_reg == ebi_pkg::EBI_RDY
    |-> req_reg.wait_states >= ebi_pkg::READY_MIN_WS)
    else $error("ready check entered without long waits");
  a_msc_window: assert property (s_last_wait |-> microstate_done_n_o)
    else $error("microstate done still active at last wait");
  a_hold_after: assert property (active && !hold_n_i && !done && !cpu_rst
    |=> state_reg != ebi_pkg::EBI_HOLD)
    else $error("hold granted mid access");

endmodule

/* File: dv/ebi_mem_model.sv */
`timescale 1ns/100ps
module ebi_mem_model (
  // Clock
  input  wire logic                  clock_i,
  // Bus from the device, and the stall limit from the testbench
  input  wire ebi_pkg::ebi_ctrl_type ctrl_i,
  input  wire logic [19:0]           addr_i,
  input  wire logic [15:0]           wdata_i,
  input  wire logic [3:0]            lim_i,
  // Answer to the device
  output logic                       ready_o,
  output logic [15:0]                rdata_o
);
  logic [15:0] mem_reg [16];
  logic [15:0] last_reg = 16'h0000;
  logic [3:0]  cnt_reg = 4'h0;
  logic        act;
  assign act = !ctrl_i.memory_strobe_n || !ctrl_i.io_strobe_n;
  // Ready rises only once the programmed stall has run out
  assign ready_o = act && (cnt_reg >= lim_i);
  always_ff @(posedge clock_i) begin
    cnt_reg <= act ? cnt_reg + 4'h1 : 4'h0;
    if (act && !ctrl_i.rw) mem_reg[addr_i[3:0]] <= wdata_i;
    if (act && ctrl_i.rw) last_reg <= mem_reg[addr_i[3:0]];
  end
  // A released bus shows the inverse of the last word, never a held value
  assign rdata_o = (act && ctrl_i.rw) ? mem_reg[addr_i[3:0]] : ~last_reg;
endmodule

/* File: dv/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  logic                  clock_i = 1'b0;
  logic                  reset_i = 1'b1;
  logic                  rst_n = 1'b1;
  logic                  req_valid = 1'b0;
  ebi_pkg::ebi_req_type  req = '0;
  // 0 processor_mode_status wr,1 mode,2 keep wr,3 keep,4 dec,5 rd,6 cond,7 set,8 clr,9 st1,10 boot,11 bio,12 hold_n,13 off_n
  logic [13:0]           cin = 14'h3000;
  logic [3:0]            lim = 4'h0;
  logic                  ack, rh, fst, rmap, btk, flg, flg_oe, c_oe, a_oe, d_oe, keep;
  logic                  gnt_n, gnt_oe, microstate_done_n, rdy, crst, ready;
  logic [15:0]           rdata, dout, din;
  logic [19:0]           faddr, addr, ad0;
  ebi_pkg::ebi_ctrl_type ctrl;
  ebi_pkg::ebi_ctrl_type cs [8];
  logic                  ms [8];
  int                    err_count = 0;
  int                    samples_checked = 0;
  int                    cycles = 0;
  int                    n;

  always #20 clock_i = ~clock_i;

  ebi_bus_interface u_dut (
    .clock_i, .reset_i, .reset_in_n_i(rst_n), .req_valid_i(req_valid), .req_i(req),
    .req_ready_o(rdy), .ack_o(ack), .rom_hit_o(rh), .rdata_o(rdata), .cpu_reset_o(crst),
    .fetch_start_o(fst), .fetch_addr_o(faddr), .processor_mode_status_write_i(cin[0]), .processor_mode_status_mode_i(cin[1]),
    .rom_mapped_o(rmap), .keeper_write_i(cin[2]), .keeper_value_i(cin[3]),
    .decode_phase_i(cin[4]), .read_phase_i(cin[5]), .conditional_execute_instr_i(cin[6]),
    .branch_taken_o(btk), .set_status_bit_instr_i(cin[7]), .clear_status_bit_instr_i(cin[8]),
    .status_word_one_load_i(cin[9]), .boot_memory_mode_select_i(cin[10]),
    .branch_condition_input_i(cin[11]), .ready_i(ready), .hold_n_i(cin[12]),
    .output_disable_n_i(cin[13]), .external_flag_output_o(flg),
    .external_flag_output_oe_o(flg_oe), .ctrl_o(ctrl), .ctrl_oe_o(c_oe), .addr_o(addr),
    .addr_oe_o(a_oe), .data_i(din), .data_o(dout), .data_oe_o(d_oe),
    .bus_keeper_enable_o(keep), .bus_grant_n_o(gnt_n), .bus_grant_n_oe_o(gnt_oe),
    .microstate_done_n_o(microstate_done_n)
  );

  ebi_mem_model u_mem (
    .clock_i, .ctrl_i(ctrl), .addr_i(addr), .wdata_i(dout), .lim_i(lim),
    .ready_o(ready), .rdata_o(din)
  );

  task automatic print_verdict();
    if (err_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [19:0] exp, input logic [19:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic pulse(input logic [13:0] m);
    @(posedge clock_i);
    cin <= cin | m;
    @(posedge clock_i);
    cin <= cin & ~m;
    #1;
  endtask

  // One bus access; n counts edges from the taking edge to the ack
  task automatic acc(input ebi_pkg::ebi_space_type sp, input logic wr, input logic [19:0] ad,
                     input logic [2:0] ws, input logic [3:0] st);
    @(posedge clock_i);
    req_valid <= 1'b1;
    req <= '{sp, wr, ad, ad[15:0] ^ 16'h5A5A, ws};
    lim <= 4'(ws) + st + 4'h1;
    @(posedge clock_i);
    req_valid <= 1'b0;
    n = 1;
    for (int k = 0; k < 20; k++) begin
      #1;
      if (k < 8) begin
        cs[k] = ctrl;
        ms[k] = microstate_done_n;
      end
      if (k == 0) ad0 = addr;
      if (ack === 1'b1) break;
      @(posedge clock_i);
      n++;
    end
  endtask

  task automatic t_reset();
    int p;
    p = 0;
    repeat (4) begin
      @(posedge clock_i);
      #1;
      if (fst === 1'b1) p++;
    end
    chk("fetch pulses", 20'h1, 20'(p));
    chk("fetch addr", ebi_pkg::RESET_VECTOR, faddr);
    chk("flag", 20'h1, 20'(flg));
    chk("ctrl idle", 20'(ebi_pkg::CTRL_IDLE), 20'(ctrl));
    chk("keeper", 20'h0, 20'(keep));
    chk("grant", 20'h1, 20'(gnt_n));
    chk("rom mapped", 20'h1, 20'(rmap));
  endtask

  task automatic t_core();
    pulse(14'h0100);
    chk("flag clr", 20'h0, 20'(flg));
    pulse(14'h0080);
    chk("flag set", 20'h1, 20'(flg));
    pulse(14'h0200);
    chk("flag st1", 20'h0, 20'(flg));
    pulse(14'h0020);
    chk("branch rd", 20'h1, 20'(btk));
    @(posedge clock_i);
    cin[11] <= 1'b1;
    pulse(14'h0060);
    chk("branch cond rd", 20'h1, 20'(btk));
    pulse(14'h0050);
    chk("branch cond dec", 20'h0, 20'(btk));
    pulse(14'h000C);
    chk("keeper on", 20'h1, 20'(keep));
  endtask

  task automatic t_bus();
    acc(ebi_pkg::EBI_SPACE_DATA, 1'b1, 20'h00003, 3'h2, 4'h0);
    chk("ws2 edges", 20'h5, 20'(n));
    chk("data wr ctrl", 20'h1A, 20'(cs[0]));
    chk("msc first", 20'h0, 20'(ms[1]));
    chk("msc last", 20'h1, 20'(ms[2]));
    acc(ebi_pkg::EBI_SPACE_DATA, 1'b0, 20'h00003, 3'h2, 4'h2);
    chk("stall edges", 20'h7, 20'(n));
    chk("rdata", 20'h05A59, 20'(rdata));
    chk("data rd ctrl", 20'h1B, 20'(cs[0]));
    acc(ebi_pkg::EBI_SPACE_IO, 1'b1, 20'hF0007, 3'h1, 4'h0);
    chk("io edges", 20'h3, 20'(n));
    chk("io ctrl", 20'h34, 20'(cs[0]));
    chk("io addr", 20'h00007, ad0);
    chk("msc ws1", 20'h1, 20'(ms[1]));
    acc(ebi_pkg::EBI_SPACE_PROG, 1'b0, 20'hF1234, 3'h0, 4'h0);
    chk("prog edges", 20'h2, 20'(n));
    chk("prog ctrl", 20'h2B, 20'(cs[0]));
    chk("prog addr", 20'hF1234, ad0);
  endtask

  task automatic t_rom();
    acc(ebi_pkg::EBI_SPACE_PROG, 1'b0, 20'h0F000, 3'h0, 4'h0);
    chk("rom hit", 20'h1, 20'(rh));
    chk("rom no bus", 20'(ebi_pkg::CTRL_IDLE), 20'(cs[0]));
    pulse(14'h0003);
    acc(ebi_pkg::EBI_SPACE_PROG, 1'b0, 20'h0F000, 3'h0, 4'h0);
    chk("override ctrl", 20'h2B, 20'(cs[0]));
    @(posedge clock_i);
    rst_n <= 1'b0;
    cin[10] <= 1'b1;
    repeat (2) @(posedge clock_i);
    #1;
    chk("cpu reset", 20'h1, 20'(crst));
    chk("flag reset", 20'h1, 20'(flg));
    @(posedge clock_i);
    rst_n <= 1'b1;
    @(posedge clock_i);
    #1;
    chk("fetch again", 20'h1, 20'(fst));
    repeat (2) @(posedge clock_i);
    cin[10] <= 1'b0;
    repeat (2) @(posedge clock_i);
    #1;
    chk("rom removed", 20'h0, 20'(rmap));
  endtask

  task automatic t_hold();
    @(posedge clock_i);
    cin[12] <= 1'b0;
    repeat (2) @(posedge clock_i);
    #1;
    chk("hold grant", 20'h0, 20'(gnt_n));
    chk("hold oe", 20'h0, 20'({c_oe, a_oe, d_oe, rdy}));
    @(posedge clock_i);
    cin[13] <= 1'b0;
    cin[12] <= 1'b1;
    repeat (2) @(posedge clock_i);
    #1;
    chk("off oe", 20'h1, 20'({gnt_oe, flg_oe, c_oe, gnt_n}));
    @(posedge clock_i);
    cin[13] <= 1'b1;
    @(posedge clock_i);
    #1;
    chk("on oe", 20'h3, 20'({c_oe, a_oe}));
  endtask

  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      print_verdict();
    end
  end

  initial begin
    repeat (2) @(posedge clock_i);
    reset_i <= 1'b0;
    t_reset();
    t_core();
    t_bus();
    t_rom();
    t_hold();
    print_verdict();
  end
endmodule
